/* spm_pkg.sv */
// Shared constants and carrier types for the priority map register block
package spm_pkg;

    localparam int SPM_REG_W = 64;
    localparam int SPM_PRI_W = 4;
    localparam int SPM_MAP_ENTRIES = 16;

    // Privilege levels
    localparam logic [1:0] SPM_LVL_0 = 2'h0;
    localparam logic [1:0] SPM_LVL_1 = 2'h1;
    localparam logic [1:0] SPM_LVL_2 = 2'h2;
    localparam logic [1:0] SPM_LVL_3 = 2'h3;

    // Exception class reported with every trap of this block
    localparam logic [5:0] SPM_EC_SYS_TRAP = 6'h18;
    // Word offset in the memory-backed register area for the table
    localparam logic [11:0] SPM_REDIRECT_OFFSET = 12'h1e8;

    localparam logic [SPM_PRI_W-1:0] SPM_REQ_RESET = 4'h0;
    localparam logic [SPM_REG_W-1:0] SPM_ZERO_WORD = 64'h0;
    localparam logic [5:0] SPM_EC_NONE = 6'h00;
    localparam logic [11:0] SPM_OFFSET_NONE = 12'h000;

    // Outcome of one access, one-hot
    typedef enum logic [3:0] {
        SPM_RES_OK = 4'h1,
        SPM_RES_UNDEF = 4'h2,
        SPM_RES_TRAP = 4'h4,
        SPM_RES_REDIRECT = 4'h8
    } spm_result_t;

    // One system register access from the core
    typedef struct packed {
        logic write;
        logic sel_map;
        logic [1:0] level;
        logic [SPM_REG_W-1:0] wdata;
    } spm_req_t;

    // Static and dynamic configuration seen by the access checks and the priority mapping
    typedef struct packed {
        logic matrix_impl;
        logic priority_support_flag;
        logic el2_impl;
        logic el2_enabled;
        logic el3_impl;
        logic map_enable;
        logic nested_virt;
        logic nested_virt_memory;
        logic matrix_enable_top;
        logic halted;
        logic secure_debug_disable;
        logic el3_trap_first;
        logic fine_grain_trap_enable;
        logic request_write_gate;
    } spm_cfg_t;

    // Answer to one access
    typedef struct packed {
        spm_result_t result;
        logic [1:0] target_level;
        logic [5:0] exc_class;
        logic [11:0] redirect_offset;
        logic [SPM_REG_W-1:0] rdata;
    } spm_resp_t;

endpackage : spm_pkg

/* spm_map_mem.sv */
// Storage for the sixteen mapping-table entries, read out from flops
module spm_map_mem
    import spm_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [SPM_REG_W-1:0] wr_data,
    // Whole table, straight from the entry flops
    output logic [SPM_REG_W-1:0] table_q
);

    // Entries carry no reset: software must load them before use
    genvar n;
    generate
        for (n = 0; n < SPM_MAP_ENTRIES; n++) begin : g_entry
            logic [SPM_PRI_W-1:0] entry_reg;
            always_ff @(posedge sys_clk) begin
                if (wr_en) begin
                    entry_reg <= wr_data[n*SPM_PRI_W +: SPM_PRI_W];
                end
            end
            assign table_q[n*SPM_PRI_W +: SPM_PRI_W] = entry_reg;
        end
    endgenerate

endmodule : spm_map_mem

/* spm_priority_map_regs.sv */
// Priority request and mapping-table registers with access checks
//////////////////////////////////////////////////////////////////////////////
module spm_priority_map_regs
    import spm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Access request
    input wire logic acc_valid,
    input wire spm_req_t acc_req,
    // Configuration
    input wire spm_cfg_t cfg,
    // Access answer
    output logic resp_valid,
    output spm_resp_t resp,
    // Effective priority to the shared compute unit arbiter
    output logic [SPM_PRI_W-1:0] eff_priority
);

    //////////////////////////////////////////////////////////////////////////
    // State
    logic [SPM_PRI_W-1:0] req_pri_reg;
    logic [SPM_PRI_W-1:0] eff_reg;
    logic [SPM_PRI_W-1:0] eff_next;
    logic resp_valid_reg;
    spm_resp_t resp_reg;
    spm_resp_t resp_next;
    logic [SPM_REG_W-1:0] table_q;

    //////////////////////////////////////////////////////////////////////////
    // Common conditions
    wire lvl0 = (acc_req.level == SPM_LVL_0);
    wire lvl1 = (acc_req.level == SPM_LVL_1);
    wire lvl2 = (acc_req.level == SPM_LVL_2);
    wire lvl3 = (acc_req.level == SPM_LVL_3);
    wire el2_on = cfg.el2_impl & cfg.el2_enabled;
    wire esm_off = cfg.el3_impl & ~cfg.matrix_enable_top;
    wire dbg_block = cfg.halted & cfg.secure_debug_disable;
    wire early_undef = dbg_block & esm_off & cfg.el3_trap_first;
    // level-3 trap from level 2 or 1
    wire trap3_raw = esm_off;
    // trap to level 3 turned undefined
    wire trap3_undef = trap3_raw & dbg_block;

    //////////////////////////////////////////////////////////////////////////
    // Table access decision
    // absent feature
    wire map_absent = ~cfg.matrix_impl;
    wire map_redirect = lvl1 & el2_on & cfg.nested_virt_memory &
                        cfg.nested_virt;
    wire map_trap2 = lvl1 & el2_on & cfg.nested_virt & ~map_redirect;
    wire map_undef_low = lvl0 | (lvl1 & ~map_redirect & ~map_trap2);
    wire map_l2_undef = lvl2 & (early_undef | trap3_undef);
    wire map_l2_trap3 = lvl2 & ~early_undef & trap3_raw & ~dbg_block;
    wire map_l3_trap3 = lvl3 & ~cfg.matrix_enable_top;
    wire map_ok = (lvl2 & ~trap3_raw) | (lvl3 & cfg.matrix_enable_top);
    wire map_raz = ~cfg.priority_support_flag | (lvl3 & ~cfg.el2_impl);

    //////////////////////////////////////////////////////////////////////////
    // Request register access decision
    wire req_absent = ~cfg.matrix_impl;
    wire req_l1_early = lvl1 & early_undef;
    wire req_l1_fgt = lvl1 & ~early_undef & acc_req.write & el2_on &
                      (~cfg.el3_impl | cfg.fine_grain_trap_enable) &
                      ~cfg.request_write_gate;
    wire req_mid = (lvl1 & ~req_l1_early & ~req_l1_fgt) |
                   (lvl2 & ~early_undef);
    wire req_mid_undef = req_mid & trap3_undef;
    wire req_mid_trap3 = req_mid & trap3_raw & ~dbg_block;
    wire req_l3_trap3 = lvl3 & ~cfg.matrix_enable_top;
    wire req_undef = lvl0 | req_l1_early | (lvl2 & early_undef) |
                     req_mid_undef;
    wire req_ok = (req_mid & ~trap3_raw) | (lvl3 & cfg.matrix_enable_top);
    wire req_raz = ~cfg.priority_support_flag;

    //////////////////////////////////////////////////////////////////////////
    // Write strobes
    wire map_wr = acc_valid & acc_req.sel_map & acc_req.write & ~map_absent &
                  map_ok & ~map_raz;
    wire req_wr = acc_valid & ~acc_req.sel_map & acc_req.write &
                  ~req_absent & req_ok & ~req_raz;

    spm_map_mem u_map_mem (
        .sys_clk(sys_clk),
        .wr_en(map_wr),
        .wr_data(acc_req.wdata),
        .table_q(table_q)
    );

    //////////////////////////////////////////////////////////////////////////
    // Answer build
    wire [SPM_REG_W-1:0] req_word = {{(SPM_REG_W-SPM_PRI_W){1'b0}},
                                     req_pri_reg};

    always_comb begin
        resp_next.result = SPM_RES_OK;
        resp_next.target_level = SPM_LVL_0;
        resp_next.exc_class = SPM_EC_NONE;
        resp_next.redirect_offset = SPM_OFFSET_NONE;
        resp_next.rdata = SPM_ZERO_WORD;
        if (acc_req.sel_map) begin
            if (map_absent | map_undef_low | map_l2_undef) begin
                resp_next.result = SPM_RES_UNDEF;
            end else if (map_redirect) begin
                resp_next.result = SPM_RES_REDIRECT;
                resp_next.redirect_offset = SPM_REDIRECT_OFFSET;
            end else if (map_trap2) begin
                resp_next.result = SPM_RES_TRAP;
                resp_next.target_level = SPM_LVL_2;
                resp_next.exc_class = SPM_EC_SYS_TRAP;
            end else if (map_l2_trap3 | map_l3_trap3) begin
                resp_next.result = SPM_RES_TRAP;
                resp_next.target_level = SPM_LVL_3;
                resp_next.exc_class = SPM_EC_SYS_TRAP;
            end else if (!acc_req.write && !map_raz) begin
                resp_next.rdata = table_q;
            end
        end else begin
            if (req_absent | req_undef) begin
                resp_next.result = SPM_RES_UNDEF;
            end else if (req_l1_fgt) begin
                resp_next.result = SPM_RES_TRAP;
                resp_next.target_level = SPM_LVL_2;
                resp_next.exc_class = SPM_EC_SYS_TRAP;
            end else if (req_mid_trap3 | req_l3_trap3) begin
                resp_next.result = SPM_RES_TRAP;
                resp_next.target_level = SPM_LVL_3;
                resp_next.exc_class = SPM_EC_SYS_TRAP;
            end else if (!acc_req.write && !req_raz) begin
                resp_next.rdata = req_word;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Effective priority
    // mapping condition
    wire map_on = ((acc_req.level == SPM_LVL_0) | lvl1) & el2_on &
                  cfg.map_enable & cfg.priority_support_flag;
    wire [SPM_PRI_W-1:0] mapped = table_q[req_pri_reg*SPM_PRI_W +: SPM_PRI_W];
    // larger value means more resource at the arbiter
    assign eff_next = map_on ? mapped : req_pri_reg;

    //////////////////////////////////////////////////////////////////////////
    // Flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_pri_reg <= SPM_REQ_RESET;
        end else if (req_wr) begin
            req_pri_reg <= acc_req.wdata[SPM_PRI_W-1:0];
        end
    end

    // effective priority registered from current state
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            eff_reg <= SPM_REQ_RESET;
        end else begin
            eff_reg <= eff_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            resp_valid_reg <= 1'b0;
            resp_reg <= '0;
        end else begin
            resp_valid_reg <= acc_valid;
            if (acc_valid) begin
                resp_reg <= resp_next;
            end
        end
    end

    assign resp_valid = resp_valid_reg;
    assign resp = resp_reg;
    assign eff_priority = eff_reg;

endmodule : spm_priority_map_regs

/* spm_arbiter_model.sv */
// Behavioural shared compute unit arbiter fed by the priority output
module spm_arbiter_model
    import spm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [SPM_PRI_W-1:0] eff_priority,
    input wire logic [SPM_PRI_W-1:0] rival_priority,
    output logic grant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic turn_reg;
    wire win = eff_priority > rival_priority;
    wire tie = eff_priority == rival_priority;
    always_ff @(posedge sys_clk) begin
        turn_reg <= rst_b && !turn_reg;
        grant <= rst_b && (win || (tie && turn_reg));
    end
endmodule : spm_arbiter_model

/* spm_regs_checker.sv */
// Access outcome and priority assertions for the register block
module spm_regs_checker
    import spm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic acc_valid,
    input wire spm_req_t acc_req,
    input wire spm_cfg_t cfg,
    input wire logic resp_valid,
    input wire spm_resp_t resp,
    input wire logic [SPM_PRI_W-1:0] eff_priority
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire go = acc_valid && cfg.matrix_impl;
    wire m = go && acc_req.sel_map;
    wire [1:0] lv = acc_req.level;
    wire l1 = lv == SPM_LVL_1 && cfg.el2_impl && cfg.el2_enabled;
    wire l2 = go && lv == SPM_LVL_2 && cfg.el3_impl;
    wire e2 = l2 && !cfg.matrix_enable_top;
    wire hd = cfg.halted && cfg.secure_debug_disable;
    wire tr = resp.result == SPM_RES_TRAP && resp.exc_class == 6'h18;
    wire fg = !cfg.el3_impl || cfg.fine_grain_trap_enable;

    a_undef_level0: assert property (
        m && lv == SPM_LVL_0 |=> resp.result == SPM_RES_UNDEF)
        else $error("level 0 table access not undefined");
    a_absent_undef: assert property (
        acc_valid && acc_req.sel_map && !cfg.matrix_impl
        |=> resp.result == SPM_RES_UNDEF) else $error("absent table");
    a_redirect_area: assert property (
        m && l1 && cfg.nested_virt && cfg.nested_virt_memory
        |=> resp.result == SPM_RES_REDIRECT
        && resp.redirect_offset == 12'h1e8) else $error("no redirect");
    a_nested_trap: assert property (
        m && l1 && cfg.nested_virt && !cfg.nested_virt_memory
        |=> tr && resp.target_level == SPM_LVL_2) else $error("no trap 2");
    a_el2_top_trap: assert property (
        e2 && !cfg.halted |=> tr && resp.target_level == SPM_LVL_3)
        else $error("level 2 access not trapped to 3");
    a_debug_undef: assert property (
        e2 && hd |=> resp.result == SPM_RES_UNDEF)
        else $error("halted access not undefined");
    a_el3_self_trap: assert property (
        go && lv == SPM_LVL_3 && !cfg.matrix_enable_top
        |=> tr && resp.target_level == SPM_LVL_3) else $error("no trap 3");
    a_fine_write: assert property (
        go && acc_req.write && !acc_req.sel_map && l1 && fg
        && !cfg.request_write_gate && cfg.matrix_enable_top
        |=> tr && resp.target_level == SPM_LVL_2) else $error("write gate");
    a_eff_follow: assert property (
        go && acc_req.write && !acc_req.sel_map && lv == SPM_LVL_3
        && cfg.matrix_enable_top && cfg.priority_support_flag
        ##1 (lv == SPM_LVL_3) [*2]
        |-> eff_priority == $past(acc_req.wdata[3:0], 2))
        else $error("priority did not follow request");

    c_level1: cover property (m && lv == SPM_LVL_1);
    c_redir: cover property (resp_valid && resp.result == SPM_RES_REDIRECT);
    c_undef: cover property (resp_valid && resp.result == SPM_RES_UNDEF);
endmodule : spm_regs_checker

bind spm_priority_map_regs spm_regs_checker u_chk (.sys_clk, .rst_b,
    .acc_valid, .acc_req, .cfg, .resp_valid, .resp, .eff_priority);

/* stream_priority_map_regs_test.sv */
// Self-checking bench for the priority map register block
module stream_priority_map_regs_test
    import spm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Implemented, supported, level 2 and 3 on, matrix enabled, gate open
    localparam spm_cfg_t BASE = 14'h3e23;
    localparam logic [63:0] TBL = 64'h0123456789abcdef;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic acc_valid = 1'h0;
    spm_req_t acc_req = '0;
    spm_cfg_t cfg = '0;
    logic resp_valid;
    logic grant;
    spm_resp_t resp;
    logic [SPM_PRI_W-1:0] eff_priority;
    int miscompares = 0;
    int n_compared = 0;
    always #20 sys_clk = ~sys_clk;

    spm_priority_map_regs u_dut (.sys_clk, .rst_b, .acc_valid, .acc_req,
        .cfg, .resp_valid, .resp, .eff_priority);
    spm_arbiter_model u_arb (.sys_clk, .rst_b, .eff_priority,
        .rival_priority(4'h7), .grant);

    task automatic stop_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string s, input logic [63:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, s, input logic [1:0] l,
        input logic [63:0] d, input spm_cfg_t c);
        @(posedge sys_clk);
        acc_valid <= 1'h1;
        cfg <= c;
        acc_req <= '{write: w, sel_map: s, level: l, wdata: d};
        @(posedge sys_clk);
        acc_valid <= 1'h0;
        #1 chk("resp_valid", 64'h1, resp_valid);
    endtask : acc

    task automatic idle(input spm_cfg_t c, input logic [1:0] l);
        @(posedge sys_clk);
        cfg <= c;
        acc_req.level <= l;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic fault(input logic w, s, input logic [1:0] l,
        input spm_cfg_t c, input spm_result_t r, input int t);
        acc(w, s, l, 64'h5, c);
        chk("result", r, resp.result);
        if (r == SPM_RES_TRAP) begin
            chk("target", 64'(t), resp.target_level);
            chk("class", 64'h18, resp.exc_class);
        end else begin
            chk("class", 64'h0, resp.exc_class);
        end
    endtask : fault

    task automatic t_map;
        spm_cfg_t c;
        c = BASE;
        acc(1'h1, 1'h1, SPM_LVL_3, TBL, c);
        acc(1'h0, 1'h1, SPM_LVL_3, 64'h0, c);
        chk("table", TBL, resp.rdata);
        for (int n = 0; n < 16; n++) begin
            acc(1'h1, 1'h0, SPM_LVL_3, 64'(n), c);
            acc(1'h0, 1'h0, SPM_LVL_3, 64'h0, c);
            chk("request", 64'(n), resp.rdata);
            c.map_enable = 1'h1;
            idle(c, n[0] ? SPM_LVL_1 : SPM_LVL_0);
            chk("mapped", 64'(15 - n), eff_priority);
            // A tie with the rival alternates, so only clear wins and losses are judged
            if (n != 8) begin
                chk("grant", 64'(n < 8), grant);
            end
            idle(c, SPM_LVL_2);
            chk("level 2", 64'(n), eff_priority);
            c.map_enable = 1'h0;
            idle(c, SPM_LVL_1);
            chk("unmapped", 64'(n), eff_priority);
        end
    endtask : t_map

    task automatic t_fault;
        spm_cfg_t c;
        c = BASE;
        fault(1'h0, 1'h1, SPM_LVL_0, c, SPM_RES_UNDEF, 0);
        c.nested_virt = 1'h1;
        c.nested_virt_memory = 1'h1;
        fault(1'h1, 1'h1, SPM_LVL_1, c, SPM_RES_REDIRECT, 0);
        chk("offset", 64'h1e8, resp.redirect_offset);
        c.nested_virt_memory = 1'h0;
        fault(1'h1, 1'h1, SPM_LVL_1, c, SPM_RES_TRAP, 2);
        c.nested_virt = 1'h0;
        fault(1'h0, 1'h1, SPM_LVL_1, c, SPM_RES_UNDEF, 0);
        c.request_write_gate = 1'h0;
        fault(1'h1, 1'h0, SPM_LVL_1, c, SPM_RES_TRAP, 2);
        c.matrix_enable_top = 1'h0;
        fault(1'h1, 1'h0, SPM_LVL_3, c, SPM_RES_TRAP, 3);
        fault(1'h1, 1'h1, SPM_LVL_2, c, SPM_RES_TRAP, 3);
        c.halted = 1'h1;
        c.secure_debug_disable = 1'h1;
        fault(1'h0, 1'h0, SPM_LVL_2, c, SPM_RES_UNDEF, 0);
        c.el3_trap_first = 1'h1;
        fault(1'h1, 1'h0, SPM_LVL_1, c, SPM_RES_UNDEF, 0);
        c = BASE;
        c.priority_support_flag = 1'h0;
        fault(1'h1, 1'h1, SPM_LVL_3, c, SPM_RES_OK, 0);
        fault(1'h0, 1'h1, SPM_LVL_3, c, SPM_RES_OK, 0);
        chk("raz", 64'h0, resp.rdata);
        c = BASE;
        c.el2_impl = 1'h0;
        fault(1'h1, 1'h1, SPM_LVL_3, c, SPM_RES_OK, 0);
        fault(1'h0, 1'h1, SPM_LVL_3, c, SPM_RES_OK, 0);
        chk("raz", 64'h0, resp.rdata);
        c.matrix_impl = 1'h0;
        fault(1'h1, 1'h1, SPM_LVL_3, c, SPM_RES_UNDEF, 0);
        acc(1'h0, 1'h1, SPM_LVL_3, 64'h0, BASE);
        chk("kept table", TBL, resp.rdata);
    endtask : t_fault

    // Mid-run reset: answer and request clear, table keeps its contents
    task automatic t_reset;
        @(posedge sys_clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        #1 chk("result after reset", 64'h0, resp.result);
        chk("eff after reset", 64'h0, eff_priority);
        acc(1'h0, 1'h0, SPM_LVL_3, 64'h0, BASE);
        chk("request after reset", 64'h0, resp.rdata);
    endtask : t_reset

    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'h1;
        #1 chk("eff reset", 64'h0, eff_priority);
        chk("resp_valid reset", 64'h0, resp_valid);
        t_map();
        t_reset();
        t_fault();
        stop_test();
    end

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule : stream_priority_map_regs_test
